// [design/aes_dec_core.sv]
// iterative aes-128 block decryptor that expands and stores all 11 round keys before the rounds
`timescale 1ns/1ps
`include "cmd_defines.svh"
module aes_dec_core (
  input logic clk,
  input logic rst_n,
  aes_if.core a
);
  logic [127:0] rk_r [0:10];
  logic [127:0] s_r;
  logic [127:0] din_r;
  logic [127:0] rk_nxt;
  logic [7:0] rcon_r;
  logic [3:0] cnt_r;
  logic done_r;
  ctl_pkg::core_state_t st_r;

  // ==========================================================
  // field arithmetic; s-boxes are computed, not tabled
  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] x, input logic [7:0] y);
    logic [7:0] p;
    logic [7:0] t;
    p = 8'h00;
    t = x;
    for (int i = 0; i < 8; i++) begin
      if (y[i]) p = p ^ t;
      t = xt(t);
    end
    return p;
  endfunction
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    r = 8'h01;
    for (int i = 7; i >= 0; i--) begin
      r = gmul(r, r);
      if (i != 0) r = gmul(r, x);
    end
    return r;
  endfunction
  function automatic logic [7:0] rl(input logic [7:0] b, input int k);
    logic [15:0] d;
    d = {b, b} << k;
    return d[15:8];
  endfunction
  function automatic logic [7:0] sb(input logic [7:0] x);
    logic [7:0] b;
    b = ginv(x);
    return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
  endfunction
  function automatic logic [7:0] isb(input logic [7:0] x);
    return ginv(rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ 8'h05);
  endfunction
  function automatic logic [127:0] expand(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [127:0] r;
    t = {sb(k[23:16]) ^ rc, sb(k[15:8]), sb(k[7:0]), sb(k[31:24])};
    r[127:96] = k[127:96] ^ t;
    r[95:64] = k[95:64] ^ r[127:96];
    r[63:32] = k[63:32] ^ r[95:64];
    r[31:0] = k[31:0] ^ r[63:32];
    return r;
  endfunction
  function automatic logic [127:0] inv_round(input logic [127:0] s, input logic [127:0] k,
                                             input logic mix);
    logic [127:0] t;
    logic [127:0] r;
    logic [7:0] o;
    for (int n = 0; n < 16; n++) begin
      t[127 - 8 * ((n % 4) + 4 * (((n / 4) + (n % 4)) % 4)) -: 8] = isb(s[127 - 8 * n -: 8]);
    end
    t = t ^ k;
    r = t;
    if (mix) begin
      for (int c = 0; c < 4; c++) begin
        for (int i = 0; i < 4; i++) begin
          o = 8'h00;
          for (int j = 0; j < 4; j++) begin
            o = o ^ gmul(t[127 - 8 * (4 * c + j) -: 8],
                         8'(32'h0e0b0d09 >> (24 - 8 * ((j - i) & 3))));
          end
          r[127 - 8 * (4 * c + i) -: 8] = o;
        end
      end
    end
    return r;
  endfunction

  // ==========================================================
  // sequencing: 10 expansion cycles, then 10 inverse rounds
  assign rk_nxt = expand(rk_r[cnt_r - 4'h1], rcon_r);
  assign a.dout = s_r;
  assign a.done = done_r;

  always_ff @(posedge clk) begin
    if (st_r == ctl_pkg::C_IDLE && a.start) begin
      rk_r[0] <= a.key;
      din_r <= a.din;
    end else if (st_r == ctl_pkg::C_EXP) begin
      rk_r[cnt_r] <= rk_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ctl_pkg::C_IDLE;
      s_r <= '0;
      rcon_r <= 8'h00;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        ctl_pkg::C_IDLE: if (a.start) begin
          rcon_r <= `AES_RCON0;
          cnt_r <= 4'h1;
          st_r <= ctl_pkg::C_EXP;
        end
        ctl_pkg::C_EXP: begin
          rcon_r <= xt(rcon_r);
          if (cnt_r == `AES_ROUNDS) begin
            s_r <= din_r ^ rk_nxt;
            cnt_r <= `AES_ROUNDS - 4'h1;
            st_r <= ctl_pkg::C_RND;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ctl_pkg::C_RND: begin
          s_r <= inv_round(s_r, rk_r[cnt_r], cnt_r != 4'h0);
          if (cnt_r == 4'h0) begin
            done_r <= 1'b1;
            st_r <= ctl_pkg::C_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end

  AST_CORE_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
    (a.start && st_r == ctl_pkg::C_IDLE) |-> !a.done [*8] ##14 a.done)
    else $error("block decrypt did not finish in 21 cycles");
endmodule

// [design/aes_if.sv]
// handshake between command engine and block decryptor
`timescale 1ns/1ps
interface aes_if;
  logic start;
  logic [127:0] key;
  logic [127:0] din;
  logic [127:0] dout;
  logic done;
  modport eng (output start, output key, output din, input dout, input done);
  modport core (input start, input key, input din, output dout, output done);
endinterface

// [design/cmd_defines.svh]
// register offsets, codes, limits and timing counts of the command executor
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH
// ==========================================================
// register map
`define OFF_CMD 12'h000
`define OFF_ARG0 12'h004
`define OFF_ARG2 12'h00c
`define OFF_RESULT 12'h010
`define OFF_STATUS 12'h014
`define OFF_MASK 12'h018
`define KIV_PAGE 6'h01
`define BUF_PAGE 4'h1
`define KIV_KEY1 4
`define KIV_IV0 8
`define KIV_IV1 12
// ==========================================================
// command codes and result values
`define CMD_DECRYPT 8'h09
`define CMD_VALREAD 8'h0a
`define RES_OK 8'h00
`define RES_ERR 8'h01
`define STS_DONE 0
`define STS_ERR 1
`define STS_BUSY 8
// ==========================================================
// limits and timing
`define BUF_BYTES 9'h100
`define BUF_BLOCKS 9'h010
`define MAX_BLOCKS 8'h08
`define VAL_BYTES 9'h005
`define SEL_KEY_B 7
`define SEL_INLINE 6
`define AES_ROUNDS 4'ha
`define AES_RCON0 8'h01
`endif

// [design/cmd_exec.sv]
// decrypt and value-read command executor behind an apb register file
`timescale 1ns/1ps
`include "cmd_defines.svh"
// ==========================================================
module cmd_exec (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic tag_req,
  output logic [7:0] tag_blk,
  output logic [5:0] tag_key_idx,
  output logic tag_key_b,
  output logic tag_key_inline,
  output logic [47:0] tag_key,
  input logic tag_done,
  input logic tag_ok,
  input logic [127:0] tag_data
);
  logic [31:0] args_r [0:2];
  logic [31:0] kiv_r [0:15];
  logic [7:0] buf_r [0:255];
  logic [7:0] cmd_r;
  logic [7:0] result_r;
  logic [1:0] sts_r;
  logic [1:0] mask_r;
  logic [1:0] ev_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic tag_req_r;
  logic [7:0] tag_blk_r;
  logic [5:0] tag_key_idx_r;
  logic tag_key_b_r;
  logic tag_key_inline_r;
  logic [47:0] tag_key_r;
  logic [7:0] voff_r;
  logic [3:0] blk_r;
  logic [3:0] left_r;
  logic [127:0] key_r;
  logic [127:0] chain_r;
  logic [127:0] ct_r;
  logic aes_start_r;
  ctl_pkg::ctl_state_t st_r;
  logic busy;
  logic a_cmd, a_arg, a_res, a_sts, a_msk, a_kiv, a_buf;
  logic [31:0] rd_d;
  logic rd_e;
  logic wr;
  logic dec_bad;
  logic val_bad;
  logic val_good;
  logic [39:0] vbytes;
  logic [7:0] arg_b [0:8];
  aes_if aes ();

  aes_dec_core u_core (.clk(pclk), .rst_n(presetn), .a(aes.core));

  // ==========================================================
  // helpers
  function automatic logic [7:0] argb(input int n);
    return args_r[n / 4][8 * (n % 4) +: 8];
  endfunction
  for (genvar g = 0; g < 9; g++) begin : g_arg
    assign arg_b[g] = args_r[g / 4][8 * (g % 4) +: 8];
  end
  function automatic logic [127:0] kiv128(input int w);
    logic [127:0] r;
    for (int i = 0; i < 16; i++) r[127 - 8 * i -: 8] = kiv_r[w + i / 4][8 * (i % 4) +: 8];
    return r;
  endfunction
  function automatic logic [127:0] blk_rd(input logic [3:0] b);
    logic [127:0] r;
    for (int i = 0; i < 16; i++) r[127 - 8 * i -: 8] = buf_r[{b, 4'(i)}];
    return r;
  endfunction
  // a value block holds v, ~v, v, then addr, ~addr, addr, ~addr
  function automatic logic vfmt_ok(input logic [127:0] d);
    return d[31:0] == ~d[63:32] && d[31:0] == d[95:64] && d[103:96] == ~d[111:104]
        && d[103:96] == d[119:112] && d[103:96] == ~d[127:120];
  endfunction

  // ==========================================================
  // apb slave: one wait-free access phase, answer registered in setup
  assign busy = st_r != ctl_pkg::S_IDLE;
  assign a_cmd = paddr == `OFF_CMD;
  assign a_arg = paddr >= `OFF_ARG0 && paddr <= `OFF_ARG2 && paddr[1:0] == 2'h0;
  assign a_res = paddr == `OFF_RESULT;
  assign a_sts = paddr == `OFF_STATUS;
  assign a_msk = paddr == `OFF_MASK;
  assign a_kiv = paddr[11:6] == `KIV_PAGE && paddr[1:0] == 2'h0;
  assign a_buf = paddr[11:8] == `BUF_PAGE && paddr[1:0] == 2'h0;
  assign wr = psel && penable && pready_r && pwrite && !pslverr_r;

  always_comb begin
    rd_d = 32'h0000_0000;
    rd_e = 1'b0;
    if (a_cmd) rd_d = {24'h000000, cmd_r};
    else if (a_arg) rd_d = args_r[paddr[3:2] - 2'h1];
    else if (a_res) rd_d = {24'h000000, result_r};
    else if (a_sts) rd_d = {23'h000000, busy, 6'h00, sts_r};
    else if (a_msk) rd_d = {30'h00000000, mask_r};
    else if (a_kiv) rd_d = kiv_r[paddr[5:2]];
    else if (a_buf) begin
      for (int l = 0; l < 4; l++) rd_d[8 * l +: 8] = buf_r[{paddr[7:2], 2'(l)}];
    end else rd_e = 1'b1;
    // a running command owns its inputs and the buffer
    if (pwrite && busy && (a_cmd || a_arg || a_kiv || a_buf)) rd_e = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= rd_e;
      prdata_r <= (pwrite || rd_e) ? 32'h0000_0000 : rd_d;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) args_r[i] <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) kiv_r[i] <= 32'h0000_0000;
      mask_r <= 2'h0;
    end else if (wr) begin
      if (a_arg) args_r[paddr[3:2] - 2'h1] <= pwdata;
      if (a_kiv) kiv_r[paddr[5:2]] <= pwdata;
      if (a_msk) mask_r <= pwdata[1:0];
    end
  end

  // ==========================================================
  // status and interrupt: a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~((wr && a_sts) ? pwdata[1:0] : 2'h0)) | ev_r;
      irq_r <= |(sts_r & mask_r);
    end
  end

  // ==========================================================
  // data buffer: software writes only while idle, so the engine never collides
  assign vbytes = {tag_data[103:96], tag_data[31:0]};
  assign val_good = st_r == ctl_pkg::S_VWAIT && tag_done && tag_ok && vfmt_ok(tag_data);

  always_ff @(posedge pclk) begin
    if (wr && a_buf) begin
      for (int l = 0; l < 4; l++) if (pstrb[l]) buf_r[{paddr[7:2], 2'(l)}] <= pwdata[8 * l +: 8];
    end
    if (st_r == ctl_pkg::S_DWAIT && aes.done) begin
      for (int i = 0; i < 16; i++) begin
        buf_r[{blk_r, 4'(i)}] <= aes.dout[127 - 8 * i -: 8] ^ chain_r[127 - 8 * i -: 8];
      end
    end
    if (val_good) begin
      for (int i = 0; i < 5; i++) buf_r[voff_r + 8'(i)] <= vbytes[8 * i +: 8];
    end
  end

  // ==========================================================
  // command sequencer
  assign dec_bad = argb(0) > 8'h01 || argb(1) > 8'h01 || argb(3) == 8'h00
                || argb(3) > `MAX_BLOCKS || {1'b0, argb(2)} + {1'b0, argb(3)} > `BUF_BLOCKS;
  assign val_bad = {1'b0, argb(1)} + `VAL_BYTES > `BUF_BYTES;
  assign aes.start = aes_start_r;
  assign aes.key = key_r;
  assign aes.din = ct_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ctl_pkg::S_IDLE;
      cmd_r <= 8'h00;
      result_r <= `RES_OK;
      ev_r <= 2'h0;
      blk_r <= 4'h0;
      left_r <= 4'h0;
      key_r <= '0;
      chain_r <= '0;
      ct_r <= '0;
      aes_start_r <= 1'b0;
      tag_req_r <= 1'b0;
      tag_blk_r <= 8'h00;
      tag_key_idx_r <= 6'h00;
      tag_key_b_r <= 1'b0;
      tag_key_inline_r <= 1'b0;
      tag_key_r <= 48'h0;
      voff_r <= 8'h00;
    end else begin
      ev_r <= 2'h0;
      aes_start_r <= 1'b0;
      tag_req_r <= 1'b0;
      unique case (st_r)
        ctl_pkg::S_IDLE: if (wr && a_cmd) begin
          cmd_r <= pwdata[7:0];
          st_r <= ctl_pkg::S_CHECK;
        end
        ctl_pkg::S_CHECK: begin
          if (cmd_r == `CMD_DECRYPT && !dec_bad) begin
            key_r <= kiv128(arg_b[0][0] ? `KIV_KEY1 : 0);
            chain_r <= kiv128(arg_b[1][0] ? `KIV_IV1 : `KIV_IV0);
            blk_r <= arg_b[2][3:0];
            left_r <= arg_b[3][3:0];
            st_r <= ctl_pkg::S_DLOAD;
          end else if (cmd_r == `CMD_VALREAD && !val_bad) begin
            tag_req_r <= 1'b1;
            tag_blk_r <= argb(0);
            voff_r <= argb(1);
            tag_key_idx_r <= arg_b[2][5:0];
            tag_key_b_r <= arg_b[2][`SEL_KEY_B];
            tag_key_inline_r <= arg_b[2][`SEL_INLINE];
            tag_key_r <= arg_b[2][`SEL_INLINE] ? {argb(8), argb(7), argb(6), argb(5),
                                                 argb(4), argb(3)} : 48'h0;
            st_r <= ctl_pkg::S_VWAIT;
          end else begin
            result_r <= `RES_ERR;
            ev_r <= 2'h3;
            st_r <= ctl_pkg::S_IDLE;
          end
        end
        ctl_pkg::S_DLOAD: begin
          ct_r <= blk_rd(blk_r);
          aes_start_r <= 1'b1;
          st_r <= ctl_pkg::S_DWAIT;
        end
        ctl_pkg::S_DWAIT: if (aes.done) begin
          chain_r <= ct_r;
          blk_r <= blk_r + 4'h1;
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            result_r <= `RES_OK;
            ev_r <= 2'h1;
            st_r <= ctl_pkg::S_IDLE;
          end else begin
            st_r <= ctl_pkg::S_DLOAD;
          end
        end
        ctl_pkg::S_VWAIT: if (tag_done) begin
          result_r <= val_good ? `RES_OK : `RES_ERR;
          ev_r <= val_good ? 2'h1 : 2'h3;
          st_r <= ctl_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign tag_req = tag_req_r;
  assign tag_blk = tag_blk_r;
  assign tag_key_idx = tag_key_idx_r;
  assign tag_key_b = tag_key_b_r;
  assign tag_key_inline = tag_key_inline_r;
  assign tag_key = tag_key_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_dec_start;
    st_r == ctl_pkg::S_CHECK && cmd_r == `CMD_DECRYPT && !dec_bad;
  endsequence
  sequence s_tag_fail;
    st_r == ctl_pkg::S_VWAIT && tag_done && !tag_ok;
  endsequence

  AST_DEC_ARGS: assert property (s_dec_start |=> blk_r == $past(arg_b[2][3:0])
    && left_r == $past(arg_b[3][3:0]) && st_r == ctl_pkg::S_DLOAD)
    else $error("decrypt arguments not taken from bytes 2 and 3");
  AST_DEC_BAD: assert property ((st_r == ctl_pkg::S_CHECK && cmd_r == `CMD_DECRYPT
    && dec_bad) |=> result_r == `RES_ERR && st_r == ctl_pkg::S_IDLE && ev_r == 2'h3)
    else $error("bad decrypt arguments not rejected");
  AST_KEY_STABLE: assert property ((st_r == ctl_pkg::S_DWAIT) |-> $stable(key_r)
    && aes.key == kiv128(arg_b[0][0] ? `KIV_KEY1 : 0))
    else $error("key changed inside a decrypt command");
  AST_CHAIN: assert property ((st_r == ctl_pkg::S_DWAIT && aes.done)
    |=> chain_r == $past(ct_r))
    else $error("chain value is not the previous ciphertext");
  AST_IN_PLACE: assert property ((st_r == ctl_pkg::S_DWAIT && aes.done)
    |=> blk_rd($past(blk_r)) == ($past(aes.dout) ^ $past(chain_r)))
    else $error("plaintext not written over its ciphertext block");
  AST_DEC_OK: assert property ((st_r == ctl_pkg::S_DWAIT && aes.done && left_r == 4'h1)
    |=> result_r == `RES_OK && !busy)
    else $error("decrypt did not end after its last block");
  AST_SEL_FIELDS: assert property (tag_req_r |-> tag_key_idx_r == arg_b[2][5:0]
    && tag_key_b_r == arg_b[2][7] && tag_key_inline_r == arg_b[2][6])
    else $error("key selector fields not decoded");
  AST_INLINE_KEY: assert property (tag_req_r |-> (tag_key_inline_r ?
    tag_key_r[7:0] == argb(3) && tag_key_r[47:40] == argb(8) : tag_key_r == 48'h0))
    else $error("inline key handling wrong");
  AST_TAG_FAIL: assert property (s_tag_fail |=> result_r == `RES_ERR && !busy)
    else $error("tag failure not reported as error");
  AST_VAL_STORE: assert property (val_good |=>
    buf_r[$past(voff_r)] == $past(tag_data[7:0])
    && buf_r[$past(voff_r) + 8'h04] == $past(tag_data[103:96]) && result_r == `RES_OK)
    else $error("value or address byte not stored");
endmodule

// [design/ctl_pkg.sv]
// state types of the command executor and the cipher core
package ctl_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CHECK = 5'h02,
    S_DLOAD = 5'h04,
    S_DWAIT = 5'h08,
    S_VWAIT = 5'h10
  } ctl_state_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_EXP = 3'h2,
    C_RND = 3'h4
  } core_state_t;
endpackage

// [verification/tag_model.sv]
// far-side tag model answering value read requests
`timescale 1ns/1ps
module tag_model (
  input wire logic pclk,
  input wire logic tag_req,
  input wire logic [7:0] tag_blk,
  input wire logic [5:0] tag_key_idx,
  input wire logic tag_key_b,
  input wire logic tag_key_inline,
  input wire logic [47:0] tag_key,
  input wire logic [7:0] lat,
  input wire logic ok_in,
  input wire logic [31:0] val,
  output logic tag_done,
  output logic tag_ok,
  output logic [127:0] tag_data
);
  logic [63:0] seen;
  logic [127:0] blk_r;
  logic ok_r;
  logic pend;
  logic [7:0] cnt;
  int n_req;
  initial begin
    tag_done = 1'b0;
    pend = 1'b0;
    ok_r = 1'b0;
    blk_r = '0;
    n_req = 0;
  end
  // outside the done pulse the lines carry the inverse, so a stale copy is never read as good
  assign tag_data = tag_done ? blk_r : ~blk_r;
  assign tag_ok = tag_done ? ok_r : ~ok_r;
  // ==========================================================
  // request capture and answer
  always @(posedge pclk) begin
    tag_done <= 1'b0;
    if (tag_req) begin
      seen <= {tag_blk, tag_key_idx, tag_key_b, tag_key_inline, tag_key};
      pend <= 1'b1;
      cnt <= lat;
      n_req <= n_req + 1;
    end else if (pend && cnt == 8'h00) begin
      // value layout: v, ~v, v, then address, ~address, address, ~address
      blk_r <= {~tag_blk, tag_blk, ~tag_blk, tag_blk, val, ~val, val};
      ok_r <= ok_in;
      tag_done <= 1'b1;
      pend <= 1'b0;
    end else if (pend) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// [verification/tb_top.sv]
// testbench for the decrypt and value read command executor
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic tag_req, tag_key_b, tag_key_inline, tag_done, tag_ok, ok_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, val;
  logic [3:0] pstrb;
  logic [7:0] tag_blk, lat;
  logic [5:0] tag_key_idx;
  logic [47:0] tag_key;
  logic [127:0] tag_data;
  logic [31:0] kw[4], cw[4], pw[4], iw[4], bad[5];
  int mismatches, n_checks, reqs;
  cmd_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .tag_req(tag_req), .tag_blk(tag_blk),
    .tag_key_idx(tag_key_idx), .tag_key_b(tag_key_b), .tag_key_inline(tag_key_inline),
    .tag_key(tag_key), .tag_done(tag_done), .tag_ok(tag_ok), .tag_data(tag_data));
  tag_model i_tag (.pclk(pclk), .tag_req(tag_req), .tag_blk(tag_blk),
    .tag_key_idx(tag_key_idx), .tag_key_b(tag_key_b), .tag_key_inline(tag_key_inline),
    .tag_key(tag_key), .lat(lat), .ok_in(ok_in), .val(val), .tag_done(tag_done),
    .tag_ok(tag_ok), .tag_data(tag_data));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, $sformatf("read %h", a));
  endtask
  task automatic irq_chk(input logic e);
    @(negedge pclk);
    chk(irq, e, "irq");
    @(posedge pclk);
  endtask
  // busy polled with a bound, then the result code compared
  task automatic run(input logic [7:0] code, input logic [7:0] res);
    int n;
    apb(1'b1, 12'h000, {24'h0, code});
    n = 0;
    do begin
      apb(1'b0, 12'h014, 32'h0);
      n++;
    end while (rd[8] !== 1'b0 && n < 200);
    if (rd[8] !== 1'b0) tmo();
    rchk(12'h010, {24'h0, res});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    lat = 8'h00;
    ok_in = 1'b1;
    val = 32'h0;
    mismatches = 0;
    n_checks = 0;
    kw = '{32'h03020100, 32'h07060504, 32'h0b0a0908, 32'h0f0e0d0c};
    cw = '{32'hd8e0c469, 32'h30047b6a, 32'h80b7cdd8, 32'h5ac5b470};
    pw = '{32'h33221100, 32'h77665544, 32'hbbaa9988, 32'hffeeddcc};
    iw = '{32'h0f1e2d3c, 32'h4b5a6978, 32'h8796a5b4, 32'hc3d2e1f0};
    bad = '{32'h01000002, 32'h01000200, 32'h00000000, 32'h09000000, 32'h020f0000};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h040 + 12'(4 * k), kw[k]);
      apb(1'b1, 12'h070 + 12'(4 * k), iw[k]);
      apb(1'b1, 12'h120 + 12'(4 * k), cw[k]);
      apb(1'b1, 12'h130 + 12'(4 * k), cw[k]);
      apb(1'b1, 12'h140 + 12'(4 * k), ~cw[k]);
      apb(1'b1, 12'h1f0 + 12'(4 * k), cw[k]);
    end
    // two equal ciphertext blocks expose the chaining value in the second result
    apb(1'b1, 12'h004, 32'h02020000);
    run(8'h09, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rchk(12'h120 + 12'(4 * k), pw[k]);
      rchk(12'h130 + 12'(4 * k), pw[k] ^ cw[k]);
      rchk(12'h140 + 12'(4 * k), ~cw[k]);
    end
    irq_chk(1'b0);
    apb(1'b1, 12'h018, 32'h1);
    irq_chk(1'b1);
    apb(1'b1, 12'h014, 32'h3);
    irq_chk(1'b0);
    // key moves to slot one and slot zero is cleared, so only a working selector passes
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h040 + 12'(4 * k), 32'h0);
      apb(1'b1, 12'h050 + 12'(4 * k), kw[k]);
    end
    apb(1'b1, 12'h004, 32'h010f0101);
    run(8'h09, 8'h00);
    for (int k = 0; k < 4; k++) rchk(12'h1f0 + 12'(4 * k), pw[k] ^ iw[k]);
    $display("decrypt tests done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h004, bad[i]);
      run(8'h09, 8'h01);
      rchk(12'h014, 32'h3);
      apb(1'b1, 12'h014, 32'h3);
    end
    run(8'h07, 8'h01);
    $display("argument error tests done");
    val <= 32'h80001234;
    lat <= 8'h05;
    apb(1'b1, 12'h1f8, 32'h00aabbcc);
    apb(1'b1, 12'h1fc, 32'h0);
    apb(1'b1, 12'h004, 32'h11c5fb2c);
    apb(1'b1, 12'h008, 32'h55443322);
    apb(1'b1, 12'h00c, 32'h00000066);
    run(8'h0a, 8'h00);
    chk(i_tag.seen, {8'h2c, 6'h05, 2'b11, 48'h665544332211}, "fields");
    rchk(12'h1f8, 32'h34aabbcc);
    rchk(12'h1fc, 32'h2c800012);
    lat <= 8'h00;
    ok_in <= 1'b0;
    apb(1'b1, 12'h004, 32'h1127fb2c);
    run(8'h0a, 8'h01);
    chk(i_tag.seen, {8'h2c, 6'h27, 2'b00, 48'h0}, "fields");
    rchk(12'h1fc, 32'h2c800012);
    reqs = i_tag.n_req;
    apb(1'b1, 12'h004, 32'h1100fc2c);
    run(8'h0a, 8'h01);
    chk(64'(i_tag.n_req), 64'(reqs), "tag request");
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1, "unmapped");
    $display("value read tests done");
    final_report();
  end
endmodule
